// *** lsp_serial_port.sv ***
// Serial host port of the matrix display driver with RAM write addressing
`timescale 1ns/1ps
module lsp_serial_port #(
    parameter logic FIXED_TAG_A = 1'b0,
    parameter logic FIXED_TAG_B = 1'b0
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_hard_clear_n,
    input wire logic i_select_n,
    input wire logic i_shift_clock,
    input wire logic i_serial_in_line,
    input wire logic i_payload_kind,
    input wire logic [1:0] i_link_select,
    input wire logic i_column_major_select,
    input wire logic i_row_flip,
    input wire logic i_column_flip,
    input wire logic i_bit_stack_order,
    input wire logic i_module_tag_a,
    input wire logic i_module_tag_b,
    input wire logic i_supply_flag,
    input wire logic [lsp_pkg::TEMP_W-1:0] i_thermal_reading,
    input wire logic i_ram_ready,
    output logic o_serial_out_line,
    output logic o_serial_out_oe,
    output logic o_cmd_valid,
    output logic [lsp_pkg::BYTE_W-1:0] o_cmd_byte,
    output logic o_ram_we,
    output logic [lsp_pkg::COL_W-1:0] o_ram_col,
    output logic [lsp_pkg::BANK_W-1:0] o_ram_bank,
    output logic [lsp_pkg::BYTE_W-1:0] o_ram_data,
    output logic o_overrun
);
    import lsp_pkg::*;

    // Fixed tag defaults above are arbitrary

    logic [SYNC_W-1:0] meta_q, sync_q;
    logic sclk_d1_q;
    logic sclk_s, sel_s, sdin_s, kind_s, hard_n_s;
    logic [1:0] link_s;
    logic sclk_rise, sclk_fall, clr;

    lsp_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [BYTE_W-1:0] sh_q;
    logic kind_bit_q;
    logic [BYTE_W-1:0] run_cnt_q;
    logic len_pend_q;

    logic [3:0] last_bit;
    logic rx_go, byte_done, is_data, is_read;
    logic [BYTE_W-1:0] rx_byte;
    logic [BYTE_W-1:0] resp;

    logic push_v_q;
    logic [WORD_W-1:0] push_w_q;
    logic [BYTE_W-1:0] tx_sh_q;
    logic [3:0] tx_cnt_q;

    lsp_stream_if #(.W(WORD_W)) rx_if ();
    lsp_stream_if #(.W(WORD_W)) wr_if ();

    // Clock, select, data, kind, hard clear and link pins go through two flops; only the second stage is looked at
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
            sclk_d1_q <= 1'b0;
        end else begin
            meta_q <= {i_link_select, i_hard_clear_n, i_payload_kind,
                       i_serial_in_line, i_select_n, i_shift_clock};
            sync_q <= meta_q;
            sclk_d1_q <= sync_q[0];
        end
    end

    assign sclk_s = sync_q[0];
    assign sel_s = sync_q[1];
    assign sdin_s = sync_q[2];
    assign kind_s = sync_q[3];
    assign hard_n_s = sync_q[4];
    assign link_s = sync_q[6:5];
    assign sclk_rise = sclk_s && !sclk_d1_q;
    assign sclk_fall = !sclk_s && sclk_d1_q;
    assign clr = i_rst || !hard_n_s;

    // Transfer state: idle while deselected or in I2C mode
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // Clock assumed low here, so no stray first edge
                    if (!sel_s && link_s != LINK_I2C) begin
                        state_q <= ST_RECV;
                    end
                end
                ST_RECV: begin
                    if (sel_s) begin
                        state_q <= ST_IDLE;
                    end else if (byte_done && is_read) begin
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    // Only a select rise ends a read; further bits are ignored
                    if (sel_s) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign last_bit = (link_s == LINK_SER3) ? SER_LAST_BIT : SPI_LAST_BIT;
    assign rx_go = (state_q == ST_RECV) && !sel_s && sclk_rise;
    assign byte_done = rx_go && (bit_cnt_q == last_bit);
    assign rx_byte = {sh_q[BYTE_W-2:0], sdin_s};

    always_comb begin
        if (link_s == LINK_SER3) begin
            is_data = kind_bit_q;
        end else if (link_s == LINK_SPI4) begin
            is_data = kind_s;
        end else begin
            is_data = (run_cnt_q != '0);
        end
    end

    assign is_read = !is_data && !len_pend_q && rx_byte[7:3] == OP_READ_HI
                     && rx_byte[2:0] <= RD_TEMP;

    // Bit receiver, MSB first; a partial byte dies with the select rise
    always_ff @(posedge i_mclk) begin
        if (clr || state_q != ST_RECV || sel_s) begin
            bit_cnt_q <= '0;
            sh_q <= '0;
            kind_bit_q <= 1'b0;
        end else if (rx_go) begin
            if (link_s == LINK_SER3 && bit_cnt_q == '0) begin
                kind_bit_q <= sdin_s;
            end else begin
                sh_q <= rx_byte;
            end
            bit_cnt_q <= (bit_cnt_q == last_bit) ? '0 : bit_cnt_q + 1'b1;
        end
    end

    // Data run length for the variants without a kind indication
    always_ff @(posedge i_mclk) begin
        if (clr || sel_s) begin
            run_cnt_q <= '0;
            len_pend_q <= 1'b0;
        end else if (byte_done && !is_data) begin
            len_pend_q <= (rx_byte == OP_DATA_LEN) && !len_pend_q;
            if (len_pend_q) begin
                run_cnt_q <= rx_byte;
            end
        end else if (byte_done && link_s == LINK_SPI3) begin
            run_cnt_q <= run_cnt_q - 1'b1;
        end
    end

    // Data and pointer commands share one queue so their order holds
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            push_v_q <= 1'b0;
            push_w_q <= '0;
            o_cmd_valid <= 1'b0;
            o_cmd_byte <= '0;
        end else begin
            push_v_q <= 1'b0;
            o_cmd_valid <= 1'b0;
            if (byte_done && is_data) begin
                push_v_q <= 1'b1;
                push_w_q <= {KIND_DATA, rx_byte};
            end else if (byte_done && !len_pend_q && rx_byte != OP_DATA_LEN
                         && !is_read) begin
                if (rx_byte[7]) begin
                    push_v_q <= 1'b1;
                    push_w_q <= {KIND_SET_X, rx_byte};
                end else if (rx_byte[7:5] == OP_SET_Y_HI) begin
                    push_v_q <= 1'b1;
                    push_w_q <= {KIND_SET_Y, rx_byte};
                end else begin
                    o_cmd_valid <= 1'b1;
                    o_cmd_byte <= rx_byte;
                end
            end
        end
    end

    // The serial side cannot stall, so a full queue is reported, not hidden
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            o_overrun <= 1'b0;
        end else if (push_v_q && !rx_if.ready) begin
            o_overrun <= 1'b1;
        end
    end

    assign rx_if.valid = push_v_q;
    assign rx_if.data = push_w_q;

    always_comb begin
        case (rx_byte[2:0])
            RD_TAG_A: resp = {1'b0, {TEMP_W{FIXED_TAG_A}}};
            RD_TAG_B: resp = {1'b0, {TEMP_W{FIXED_TAG_B}}};
            RD_MOD_A: resp = {1'b0, {TEMP_W{i_module_tag_a}}};
            RD_MOD_B: resp = {1'b0, {TEMP_W{i_module_tag_b}}};
            RD_SUPPLY: resp = {1'b0, {TEMP_W{i_supply_flag}}};
            RD_TEMP: resp = {1'b0, i_thermal_reading};
            default: resp = '0;
        endcase
    end

    // Read byte: new bit on each fall, line released on the eighth rise
    always_ff @(posedge i_mclk) begin
        if (clr) begin
            tx_sh_q <= '0;
            tx_cnt_q <= '0;
            o_serial_out_line <= 1'b0;
            o_serial_out_oe <= 1'b0;
        end else if (byte_done && is_read) begin
            tx_sh_q <= resp;
            tx_cnt_q <= '0;
        end else if (state_q != ST_SEND || sel_s) begin
            o_serial_out_oe <= 1'b0;
            tx_cnt_q <= '0;
        end else if (sclk_fall && tx_cnt_q != TX_BITS) begin
            o_serial_out_line <= tx_sh_q[BYTE_W-1];
            tx_sh_q <= {tx_sh_q[BYTE_W-2:0], 1'b0};
            o_serial_out_oe <= 1'b1;
            tx_cnt_q <= tx_cnt_q + 1'b1;
        end else if (sclk_rise && tx_cnt_q == TX_BITS) begin
            o_serial_out_oe <= 1'b0;
        end
    end

    lsp_fifo #(
        .W(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_clr(clr),
        .s_in(rx_if),
        .s_out(wr_if)
    );

    lsp_addr_gen u_addr (
        .i_mclk(i_mclk),
        .i_clr(clr),
        .s_in(wr_if),
        .i_ram_ready(i_ram_ready),
        .i_column_major_select(i_column_major_select),
        .i_row_flip(i_row_flip),
        .i_column_flip(i_column_flip),
        .i_bit_stack_order(i_bit_stack_order),
        .o_we(o_ram_we),
        .o_col(o_ram_col),
        .o_bank(o_ram_bank),
        .o_data(o_ram_data)
    );

    chk_dc_pin: assert property (@(posedge i_mclk) disable iff (clr)
        byte_done && link_s == LINK_SPI4 && kind_s
        |=> push_v_q && push_w_q[WORD_W-1:BYTE_W] == KIND_DATA)
        else $error("four-line data byte not queued");
    chk_idle_reset: assert property (@(posedge i_mclk) disable iff (clr)
        sel_s |=> bit_cnt_q == 4'h0 && !o_serial_out_oe)
        else $error("receiver active while deselected");
    chk_oe_send: assert property (@(posedge i_mclk) disable iff (clr)
        o_serial_out_oe |-> state_q == ST_SEND && tx_cnt_q != 4'h0)
        else $error("output driven outside a read");
    chk_tx_release: assert property (@(posedge i_mclk) disable iff (clr)
        state_q == ST_SEND && !sel_s && sclk_rise && tx_cnt_q == TX_BITS
        |=> !o_serial_out_oe)
        else $error("output not released after eighth bit");
    chk_run_cmd: assert property (@(posedge i_mclk) disable iff (clr)
        $rose(sel_s) && link_s == LINK_SPI3 |=> run_cnt_q == 8'h0 && bit_cnt_q == 4'h0)
        else $error("data run survived deselect");
    chk_temp_byte: assert property (@(posedge i_mclk) disable iff (clr)
        byte_done && is_read && rx_byte[2:0] == RD_TEMP
        |=> tx_sh_q[TEMP_W-1:0] == $past(i_thermal_reading) && !tx_sh_q[7])
        else $error("temperature byte wrong");
endmodule

// *** lsp_pkg.sv ***
// Shared constants for the display serial host port and its RAM address logic
package lsp_pkg;
    localparam logic [1:0] LINK_SPI3 = 2'h0;
    localparam logic [1:0] LINK_SPI4 = 2'h1;
    localparam logic [1:0] LINK_I2C = 2'h2;
    localparam logic [1:0] LINK_SER3 = 2'h3;

    localparam int COL_W = 7;
    localparam int BANK_W = 5;
    localparam int BYTE_W = 8;
    localparam int KIND_W = 2;
    localparam int WORD_W = KIND_W + BYTE_W;
    localparam int TEMP_W = 7;
    localparam int FIFO_DEPTH = 4;

    localparam logic [COL_W-1:0] X_MAX = 7'h5f;
    localparam logic [BANK_W-1:0] Y_MAX = 5'h10;

    localparam logic [KIND_W-1:0] KIND_DATA = 2'h0;
    localparam logic [KIND_W-1:0] KIND_SET_X = 2'h1;
    localparam logic [KIND_W-1:0] KIND_SET_Y = 2'h2;

    localparam logic [7:0] OP_DATA_LEN = 8'h20;
    localparam logic [2:0] OP_SET_Y_HI = 3'h2;
    localparam logic [4:0] OP_READ_HI = 5'h02;
    localparam logic [2:0] RD_TAG_A = 3'h0;
    localparam logic [2:0] RD_TAG_B = 3'h1;
    localparam logic [2:0] RD_MOD_A = 3'h2;
    localparam logic [2:0] RD_MOD_B = 3'h3;
    localparam logic [2:0] RD_SUPPLY = 3'h4;
    localparam logic [2:0] RD_TEMP = 3'h5;

    localparam logic [3:0] SPI_LAST_BIT = 4'h7;
    localparam logic [3:0] SER_LAST_BIT = 4'h8;
    localparam logic [3:0] TX_BITS = 4'h8;

    localparam int SYNC_W = 7;
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h12;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RECV = 3'b010,
        ST_SEND = 3'b100
    } lsp_state_t;
endpackage

// *** lsp_stream_if.sv ***
// Valid/ready word stream between the port's internal modules
`timescale 1ns/1ps
interface lsp_stream_if #(
    parameter int W = 10
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** lsp_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lsp_fifo #(
    parameter int W = 10,
    parameter int DEPTH = 4
) (
    input wire logic i_mclk,
    input wire logic i_clr,
    lsp_stream_if.snk s_in,
    lsp_stream_if.src s_out
);
    import lsp_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign s_in.ready = (cnt_q != (AW+1)'(DEPTH));
    assign s_out.valid = (cnt_q != '0);
    assign s_out.data = mem_q[rd_q];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wr_q] <= s_in.data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_clr) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** lsp_addr_gen.sv ***
// Display RAM write pointer with auto-increment, wrap and mirroring
`timescale 1ns/1ps
module lsp_addr_gen (
    input wire logic i_mclk,
    input wire logic i_clr,
    lsp_stream_if.snk s_in,
    input wire logic i_ram_ready,
    input wire logic i_column_major_select,
    input wire logic i_row_flip,
    input wire logic i_column_flip,
    input wire logic i_bit_stack_order,
    output logic o_we,
    output logic [lsp_pkg::COL_W-1:0] o_col,
    output logic [lsp_pkg::BANK_W-1:0] o_bank,
    output logic [lsp_pkg::BYTE_W-1:0] o_data
);
    import lsp_pkg::*;
    logic [COL_W-1:0] x_q;
    logic [BANK_W-1:0] y_q;
    logic [KIND_W-1:0] kind;
    logic [BYTE_W-1:0] byte_in, byte_rev;
    logic acc, wr;

    assign s_in.ready = i_ram_ready;
    assign acc = s_in.valid && i_ram_ready;
    assign kind = s_in.data[WORD_W-1:BYTE_W];
    assign byte_in = s_in.data[BYTE_W-1:0];
    assign wr = acc && (kind == KIND_DATA);

    for (genvar b = 0; b < BYTE_W; b++) begin : g_rev
        assign byte_rev[b] = byte_in[BYTE_W-1-b];
    end

    always_ff @(posedge i_mclk) begin
        if (i_clr) begin
            x_q <= '0;
            y_q <= '0;
        end else if (acc && kind == KIND_SET_X) begin
            x_q <= byte_in[COL_W-1:0];
        end else if (acc && kind == KIND_SET_Y) begin
            y_q <= byte_in[BANK_W-1:0];
        end else if (wr && !i_column_major_select) begin
            if (x_q == X_MAX) begin
                x_q <= '0;
                y_q <= (y_q == Y_MAX) ? '0 : y_q + 1'b1;
            end else begin
                x_q <= x_q + 1'b1;
            end
        end else if (wr) begin
            if (y_q == Y_MAX) begin
                y_q <= '0;
                x_q <= (x_q == X_MAX) ? '0 : x_q + 1'b1;
            end else begin
                y_q <= y_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_clr) begin
            o_we <= 1'b0;
            o_col <= '0;
            o_bank <= '0;
            o_data <= '0;
        end else begin
            o_we <= wr;
            if (wr) begin
                o_col <= i_column_flip ? X_MAX - x_q : x_q;
                o_bank <= i_row_flip ? Y_MAX - y_q : y_q;
                o_data <= i_bit_stack_order ? byte_rev : byte_in;
            end
        end
    end

    chk_horiz_step: assert property (@(posedge i_mclk) disable iff (i_clr)
        wr && !i_column_major_select && x_q != X_MAX
        |=> x_q == $past(x_q) + 7'h1 && y_q == $past(y_q))
        else $error("horizontal step wrong");
    chk_vert_step: assert property (@(posedge i_mclk) disable iff (i_clr)
        wr && i_column_major_select && y_q == Y_MAX && x_q != X_MAX
        |=> y_q == 5'h0 && x_q == $past(x_q) + 7'h1)
        else $error("vertical wrap wrong");
    chk_last_wrap: assert property (@(posedge i_mclk) disable iff (i_clr)
        wr && x_q == X_MAX && y_q == Y_MAX |=> x_q == 7'h0 && y_q == 5'h0)
        else $error("final address did not wrap");
    chk_mirror_map: assert property (@(posedge i_mclk) disable iff (i_clr)
        wr && i_row_flip && i_column_flip
        |=> o_we && o_bank == Y_MAX - $past(y_q) && o_col == X_MAX - $past(x_q))
        else $error("mirrored address wrong");
endmodule

// *** lsp_host_model.sv ***
// Host microcontroller model: serial bus master for the display port
`timescale 1ns/1ps
module lsp_host_model (
    input wire logic i_mclk,
    input wire logic [1:0] i_link,
    input wire logic i_sio,
    output logic o_select_n,
    output logic o_shift_clock,
    output logic o_serial_in_line,
    output logic o_serial_in_line_oe,
    output logic o_payload_kind
);
    import lsp_pkg::*;
    initial begin
        o_select_n = 1'b1;
        o_shift_clock = 1'b0;
        o_serial_in_line = 1'b0;
        o_serial_in_line_oe = 1'b1;
        o_payload_kind = 1'b0;
    end
    // Four mclk per half period gives the 80 ns shift clock
    task automatic half();
        repeat (4) @(negedge i_mclk);
    endtask
    task automatic sel(input logic v);
        @(negedge i_mclk);
        o_shift_clock = 1'b0;
        o_select_n = v;
        o_serial_in_line_oe = 1'b1;
        half();
    endtask
    // Data moves with the falling clock, so it is stable at the rise
    task automatic bits(input logic [8:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            o_shift_clock = 1'b0;
            o_serial_in_line = v[i];
            half();
            o_shift_clock = 1'b1;
            half();
        end
    endtask
    task automatic snd(input logic kind, input logic [7:0] b);
        o_payload_kind = kind;
        if (i_link == LINK_SER3) begin
            bits({kind, b}, 9);
        end else begin
            bits({1'b0, b}, 8);
        end
    endtask
    // Released line keeps toggling so a stale bit never looks valid
    task automatic rd(input logic [7:0] cmd, output logic [7:0] r);
        snd(1'b0, cmd);
        for (int i = 7; i >= 0; i--) begin
            o_shift_clock = 1'b0;
            o_serial_in_line_oe = 1'b0;
            o_serial_in_line = ~o_serial_in_line;
            half();
            o_shift_clock = 1'b1;
            r[i] = i_sio;
            half();
        end
    endtask
endmodule

// *** tb_lcd_serial_host_port_ram_addressing.sv ***
// Self-checking bench for the serial host port and RAM addressing
`timescale 1ns/1ps
module tb_lcd_serial_host_port_ram_addressing;
    import lsp_pkg::*;
    // Tag values are arbitrary
    localparam logic TAG_A = 1'b0;
    localparam logic TAG_B = 1'b1;
    logic i_mclk, i_rst, i_hard_clear_n, i_column_major_select, i_row_flip;
    logic i_column_flip, i_bit_stack_order, i_module_tag_a, i_module_tag_b;
    logic i_supply_flag, i_ram_ready;
    logic [1:0] i_link_select;
    logic [TEMP_W-1:0] i_thermal_reading;
    logic sel_n, sck, h_d, h_oe, kind, o_serial_out_line, o_serial_out_oe;
    logic o_cmd_valid, o_ram_we, o_overrun;
    logic ram_hold;
    logic [7:0] o_cmd_byte, o_ram_data;
    logic [6:0] o_ram_col;
    logic [4:0] o_ram_bank;
    // Line released by both sides shows the inverse, so a late bit is caught
    wire sio = o_serial_out_oe ? o_serial_out_line : (h_oe ? h_d : ~o_serial_out_line);
    int mx, my, bad_count, check_count;
    logic [19:0] ram_q[$];
    logic [7:0] cmd_q[$];

    lsp_host_model host (.i_mclk(i_mclk), .i_link(i_link_select), .i_sio(sio),
        .o_select_n(sel_n), .o_shift_clock(sck), .o_serial_in_line(h_d), .o_serial_in_line_oe(h_oe),
        .o_payload_kind(kind));
    lsp_serial_port #(.FIXED_TAG_A(TAG_A), .FIXED_TAG_B(TAG_B)) dut (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_hard_clear_n(i_hard_clear_n), .i_select_n(sel_n),
        .i_shift_clock(sck), .i_serial_in_line(sio), .i_payload_kind(kind),
        .i_link_select(i_link_select), .i_column_major_select(i_column_major_select),
        .i_row_flip(i_row_flip), .i_column_flip(i_column_flip),
        .i_bit_stack_order(i_bit_stack_order), .i_module_tag_a(i_module_tag_a),
        .i_module_tag_b(i_module_tag_b), .i_supply_flag(i_supply_flag),
        .i_thermal_reading(i_thermal_reading), .i_ram_ready(i_ram_ready),
        .o_serial_out_line(o_serial_out_line), .o_serial_out_oe(o_serial_out_oe),
        .o_cmd_valid(o_cmd_valid), .o_cmd_byte(o_cmd_byte), .o_ram_we(o_ram_we),
        .o_ram_col(o_ram_col), .o_ram_bank(o_ram_bank), .o_ram_data(o_ram_data),
        .o_overrun(o_overrun));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // Random stalls on the RAM side keep the queue partly filled
    always @(negedge i_mclk) i_ram_ready <= !ram_hold && ($urandom % 4 != 0);

    task final_report();
        $display("comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task tally(input string w, input logic [19:0] e, input logic [19:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    task chk_ram(input string w, input logic [19:0] e, input logic [19:0] g);
        tally(w, e, g);
    endtask
    task chk_byte(input string w, input logic [7:0] e, input logic [7:0] g);
        tally(w, 20'(e), 20'(g));
    endtask
    task chk_flag(input string w, input logic e, input logic g);
        tally(w, 20'(e), 20'(g));
    endtask

    // Reference pointer model; flips are read as the word is queued
    task put(input logic [7:0] d);
        logic [7:0] q;
        for (int i = 0; i < 8; i++) q[i] = i_bit_stack_order ? d[7-i] : d[i];
        ram_q.push_back({i_column_flip ? 7'(95 - mx) : 7'(mx),
            i_row_flip ? 5'(16 - my) : 5'(my), q});
        if (!i_column_major_select) begin
            my = (mx == 95) ? ((my == 16) ? 0 : my + 1) : my;
            mx = (mx == 95) ? 0 : mx + 1;
        end else begin
            mx = (my == 16) ? ((mx == 95) ? 0 : mx + 1) : mx;
            my = (my == 16) ? 0 : my + 1;
        end
    endtask
    task dat();
        logic [7:0] d;
        d = 8'($urandom);
        put(d);
        host.snd(1'b1, d);
    endtask
    task setp(input int x, input int y);
        mx = x;
        my = y;
        host.snd(1'b0, 8'h80 | 8'(x));
        host.snd(1'b0, 8'h40 | 8'(y));
    endtask
    task done(input string name);
        int n;
        n = 0;
        while ((ram_q.size() != 0 || cmd_q.size() != 0) && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
        repeat (8) @(negedge i_mclk);
        if (n >= 400) begin
            bad_count++;
            $display("ERROR %s expected drained seen pending", name);
            final_report();
        end
        $display("test %s done, errors %0d", name, bad_count);
    endtask

    always @(negedge i_mclk) begin
        if (o_ram_we === 1'b1) begin
            if (ram_q.size() == 0) chk_ram("ram write", 20'bx, {o_ram_col, o_ram_bank, o_ram_data});
            else chk_ram("ram write", ram_q.pop_front(), {o_ram_col, o_ram_bank, o_ram_data});
        end
        if (o_cmd_valid === 1'b1) begin
            if (cmd_q.size() == 0) chk_byte("command", 8'bx, o_cmd_byte);
            else chk_byte("command", cmd_q.pop_front(), o_cmd_byte);
        end
    end

    initial begin
        logic [7:0] r;
        logic [7:0] e;
        int s;
        s = $urandom(57);
        i_rst = 1'b1;
        i_hard_clear_n = 1'b1;
        {i_column_major_select, i_row_flip, i_column_flip, i_bit_stack_order} = 4'($urandom);
        {i_module_tag_a, i_module_tag_b, i_supply_flag} = 3'($urandom);
        ram_hold = 1'b0;
        i_link_select = LINK_SPI4;
        i_thermal_reading = 7'($urandom);
        repeat (10) @(negedge i_mclk);
        i_rst = 1'b0;
        repeat (5) @(negedge i_mclk);
        for (int v = 0; v < 2; v++) begin
            i_column_major_select = v[0];
            host.sel(1'b0);
            setp(v ? 5 : 94, v ? 15 : 0);
            repeat (3) dat();
            host.sel(1'b1);
            done("pointer order");
        end
        i_link_select = LINK_SER3;
        host.sel(1'b0);
        for (int v = 0; v < 2; v++) begin
            i_column_major_select = v[0];
            setp(95, 16);
            repeat (2) dat();
            done("wrap");
        end
        for (int k = 0; k < 8; k++) begin
            {i_row_flip, i_column_flip, i_bit_stack_order} = 3'(k);
            dat();
            done("mirror");
        end
        host.sel(1'b1);
        i_link_select = LINK_SPI3;
        host.bits(9'h0ff, 8);
        host.sel(1'b0);
        host.snd(1'b0, OP_DATA_LEN);
        host.snd(1'b0, 8'h01);
        dat();
        cmd_q.push_back(8'h01);
        host.snd(1'b1, 8'h01);
        host.sel(1'b1);
        done("length");
        host.sel(1'b0);
        host.snd(1'b0, OP_DATA_LEN);
        host.snd(1'b0, 8'h03);
        dat();
        host.bits(9'h0aa, 4);
        host.sel(1'b1);
        host.sel(1'b0);
        cmd_q.push_back(8'h03);
        host.snd(1'b0, 8'h03);
        host.sel(1'b1);
        done("abort");
        i_link_select = LINK_I2C;
        host.sel(1'b0);
        host.snd(1'b1, 8'h5a);
        chk_flag("output enable", 1'b0, o_serial_out_oe);
        host.sel(1'b1);
        done("link off");
        for (int l = 0; l < 4; l++) begin
            if (l == 2) continue;
            i_link_select = 2'(l);
            for (int c = 0; c < 6; c++) begin
                {i_module_tag_a, i_module_tag_b, i_supply_flag} = 3'($urandom);
                i_thermal_reading = 7'($urandom);
                e = {1'b0, {7{c == 0 ? TAG_A : c == 1 ? TAG_B : c == 2 ? i_module_tag_a :
                    c == 3 ? i_module_tag_b : i_supply_flag}}};
                if (c == 5) e = {1'b0, i_thermal_reading};
                host.sel(1'b0);
                host.rd(8'h10 | 8'(c), r);
                chk_byte("read byte", e, r);
                host.half();
                chk_flag("output enable", 1'b0, o_serial_out_oe);
                host.sel(1'b1);
            end
            done("read");
        end
        i_link_select = LINK_SPI4;
        ram_hold = 1'b1;
        host.sel(1'b0);
        repeat (FIFO_DEPTH) dat();
        host.snd(1'b1, 8'h5a);
        repeat (4) @(negedge i_mclk);
        chk_flag("overrun", 1'b1, o_overrun);
        ram_hold = 1'b0;
        host.sel(1'b1);
        done("fifo");
        i_link_select = LINK_SER3;
        host.sel(1'b0);
        setp(10, 3);
        done("preclear");
        host.bits(9'h1ff, 5);
        i_hard_clear_n = 1'b0;
        repeat (6) @(negedge i_mclk);
        i_hard_clear_n = 1'b1;
        repeat (6) @(negedge i_mclk);
        mx = 0;
        my = 0;
        dat();
        done("hard clear");
        chk_flag("overrun", 1'b0, o_overrun);
        host.sel(1'b1);
        final_report();
    end
endmodule
